// ---- common/vcx_consts.svh ----
// Offsets, field positions, reset values and timing counts of the matrix.
`ifndef VCX_CONSTS_SVH
`define VCX_CONSTS_SVH
`define VCX_NCP          4
`define VCX_OFS_ROUTE0   8'h00
`define VCX_OFS_PG_CFG   8'h10
`define VCX_OFS_TIMES    8'h14
`define VCX_OFS_CMD      8'h18
`define VCX_OFS_STATUS   8'h1C
`define VCX_OFS_LAST     8'h1C
`define VCX_ROUTE_W      4
`define VCX_PG_W         17
`define VCX_HO_LSB       0
`define VCX_HO_W         7
`define VCX_WTR_LSB      8
`define VCX_WTR_W        4
`define VCX_CMD_W        3
`define VCX_RST_HO       7'h00
`define VCX_RST_WTR      4'h5
`define VCX_CLK_NS       100
`define VCX_MS_NS        1000000
`define VCX_MS_CYCLES    (`VCX_MS_NS / `VCX_CLK_NS)
`define VCX_HO_STEP_MS   100
`define VCX_WTR_MIN_MS   60000
`define VCX_SWITCH_MS    50
`endif

// ---- common/vcx_pkg.sv ----
// Types shared by the path cross-connect matrix.
package vcx_pkg;
   typedef struct packed {
      logic [7:0] data;
      logic       clk;
      logic       fs;
      logic       ssf;
      logic       tsf;
      logic       tsd;
   } vcx_cp_in_t;
   typedef struct packed {
      logic [7:0] data;
      logic       clk;
      logic       fs;
      logic       ssf;
   } vcx_cp_out_t;
   typedef enum logic [1:0] {
      VCX_INHERENT, VCX_NONINTRUSIVE, VCX_SUBLAYER
   } vcx_variant_t;
   typedef struct packed {
      logic       bidir;
      logic [1:0] src;
      logic       en;
   } vcx_route_t;
   typedef struct packed {
      logic [1:0]   p_out;
      logic [1:0]   w_out;
      logic [1:0]   n_in;
      logic [1:0]   n_out;
      logic [1:0]   p_in;
      logic [1:0]   w_in;
      logic         bidir;
      logic         revert;
      vcx_variant_t variant;
      logic         en;
   } vcx_pg_cfg_t;
   typedef enum logic [2:0] {
      VCX_CLEAR_CMD, VCX_LOCKOUT_CMD, VCX_FORCE_PROT, VCX_FORCE_WORK,
      VCX_MANUAL_PROT, VCX_MANUAL_WORK
   } vcx_cmd_t;
   typedef enum logic [1:0] {VCX_DIR_NONE, VCX_DIR_WORK, VCX_DIR_PROT} vcx_dir_t;
   typedef enum logic [1:0] {VCX_ST_WORK, VCX_ST_PROT, VCX_ST_WTR} vcx_state_t;
endpackage

// ---- logic/vcx_cross_connect.sv ----
// Path cross-connect matrix with unequipped fill and a 1+1 SNC selector.
`timescale 1ns/1ps
`default_nettype none
`include "vcx_consts.svh"
module vcx_cross_connect #(
   parameter int MS_CYCLES = `VCX_MS_CYCLES
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   // APB slave
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [7:0]           paddr_i,
   input  wire logic [31:0]          pwdata_i,
   output logic [31:0]               prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   // Connection points
   input  wire vcx_pkg::vcx_cp_in_t  cp_i [`VCX_NCP],
   input  wire logic                 timing_ref_clock_i,
   input  wire logic                 timing_ref_fs_i,
   output var vcx_pkg::vcx_cp_out_t  cp_o [`VCX_NCP]
);
   localparam int NCP = `VCX_NCP;

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a <= `VCX_OFS_LAST) && (a[1:0] == 2'h0);
   endfunction

   vcx_pkg::vcx_cp_in_t  sy1_r [NCP];
   vcx_pkg::vcx_cp_in_t  sy2_r [NCP];
   vcx_pkg::vcx_route_t  route_r [NCP];
   vcx_pkg::vcx_pg_cfg_t pg_r;
   vcx_pkg::vcx_cmd_t    cmd_r;
   vcx_pkg::vcx_dir_t    dir;
   vcx_pkg::vcx_state_t  state_r;
   vcx_pkg::vcx_state_t  state_nxt;
   vcx_pkg::vcx_cp_out_t uneq;
   logic [1:0]           ref1_r;
   logic [1:0]           ref2_r;
   logic [6:0]           ho_steps_r;
   logic [3:0]           wtr_min_r;
   logic [31:0]          prdata_r;
   logic [31:0]          rd_val;
   logic [23:0]          div_r;
   logic [19:0]          wtr_cnt_r;
   logic [19:0]          wtr_ms;
   logic [13:0]          ho_ms;
   logic [3:0]           raw;
   logic [3:0]           filt;
   logic                 ms_tick;
   logic                 hit;
   logic                 wr_en;
   logic                 rev;
   logic                 inh;
   logic                 sel_prot;
   logic                 wtr_done;

   // Every connection-point and timing-reference input passes two flops before any logic reads it; APB inputs are used directly.
   genvar g;
   generate
      for (g = 0; g < NCP; g++) begin : g_sync
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               sy1_r[g] <= '0;
               sy2_r[g] <= '0;
            end else begin
               sy1_r[g] <= cp_i[g];
               sy2_r[g] <= sy1_r[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ref1_r <= 2'h0;
         ref2_r <= 2'h0;
      end else begin
         ref1_r <= {timing_ref_fs_i, timing_ref_clock_i};
         ref2_r <= ref1_r;
      end
   end

   // All-zero bytes give zero BIP-2, so a plain zero stream is a valid
   // unequipped VC-12; its clock and frame follow the timing reference.
   assign uneq = '{data: 8'h00, clk: ref2_r[0], fs: ref2_r[1], ssf: 1'b0};

   // APB slave: zero wait states, unmapped offsets answer with an error.
   assign hit       = reg_hit(paddr_i);
   assign wr_en     = psel_i & penable_i & pwrite_i & hit;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;
   assign prdata_o  = prdata_r;

   always_comb begin
      rd_val = 32'h0;
      case (paddr_i)
         `VCX_OFS_PG_CFG: rd_val = 32'(pg_r);
         `VCX_OFS_TIMES:  rd_val = {20'h0, wtr_min_r, 1'b0, ho_steps_r};
         `VCX_OFS_CMD:    rd_val = {29'h0, cmd_r};
         `VCX_OFS_STATUS: rd_val = {25'h0, filt, state_r, sel_prot};
         default: begin
            if (hit) begin
               rd_val = 32'(route_r[paddr_i[3:2]]);
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_r <= 32'h0;
      end else if (psel_i & ~penable_i) begin
         prdata_r <= rd_val;
      end
   end

   generate
      for (g = 0; g < NCP; g++) begin : g_route
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               route_r[g] <= '0;
            end else if (wr_en && paddr_i == 8'(`VCX_OFS_ROUTE0 + 4 * g)) begin
               route_r[g] <= pwdata_i[`VCX_ROUTE_W-1:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pg_r       <= '0;
         ho_steps_r <= `VCX_RST_HO;
         wtr_min_r  <= `VCX_RST_WTR;
         cmd_r      <= vcx_pkg::VCX_CLEAR_CMD;
      end else if (wr_en) begin
         if (paddr_i == `VCX_OFS_PG_CFG) begin
            pg_r <= pwdata_i[`VCX_PG_W-1:0];
         end
         if (paddr_i == `VCX_OFS_TIMES) begin
            ho_steps_r <= pwdata_i[`VCX_HO_LSB +: `VCX_HO_W];
            wtr_min_r  <= pwdata_i[`VCX_WTR_LSB +: `VCX_WTR_W];
         end
         if (paddr_i == `VCX_OFS_CMD) begin
            cmd_r <= vcx_pkg::vcx_cmd_t'(pwdata_i[`VCX_CMD_W-1:0]);
         end
      end
   end

   // Millisecond tick for the hold-off and restore timers.
   assign ms_tick = (div_r == 24'(MS_CYCLES - 1));
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_r <= 24'h0;
      end else begin
         div_r <= ms_tick ? 24'h0 : div_r + 24'h1;
      end
   end

   // Fail and degrade sources depend on the monitoring variant.
   assign rev    = pg_r.revert;
   assign inh    = (pg_r.variant == vcx_pkg::VCX_INHERENT);
   assign raw[0] = inh ? sy2_r[pg_r.w_in].ssf : sy2_r[pg_r.w_in].tsf;
   assign raw[1] = inh ? sy2_r[pg_r.p_in].ssf : sy2_r[pg_r.p_in].tsf;
   assign raw[2] = ~inh & sy2_r[pg_r.w_in].tsd;
   assign raw[3] = ~inh & sy2_r[pg_r.p_in].tsd;
   assign ho_ms  = 14'(ho_steps_r * `VCX_HO_STEP_MS);
   assign wtr_ms = 20'(wtr_min_r * `VCX_WTR_MIN_MS);

   // Hold-off: a condition must persist before it counts; it clears at once.
   generate
      for (g = 0; g < 4; g++) begin : g_hold
         logic [13:0] cnt_r;
         logic        on_r;
         assign filt[g] = on_r;
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               cnt_r <= 14'h0;
               on_r  <= 1'b0;
            end else if (!raw[g] || !pg_r.en) begin
               cnt_r <= 14'h0;
               on_r  <= 1'b0;
            end else if (cnt_r >= ho_ms) begin
               on_r  <= 1'b1;
            end else if (ms_tick) begin
               cnt_r <= cnt_r + 14'h1;
            end
         end
      end
   endgenerate

   // Request ranking; forced and manual switches to work are void in revertive mode, lockout is not.
   always_comb begin
      dir = vcx_pkg::VCX_DIR_NONE;
      if (cmd_r == vcx_pkg::VCX_LOCKOUT_CMD) begin
         dir = vcx_pkg::VCX_DIR_WORK;
      end else if (cmd_r == vcx_pkg::VCX_FORCE_PROT) begin
         dir = vcx_pkg::VCX_DIR_PROT;
      end else if (cmd_r == vcx_pkg::VCX_FORCE_WORK && !rev) begin
         dir = vcx_pkg::VCX_DIR_WORK;
      end else if (filt[1]) begin
         dir = vcx_pkg::VCX_DIR_WORK;
      end else if (filt[0]) begin
         dir = vcx_pkg::VCX_DIR_PROT;
      end else if (filt[3]) begin
         dir = vcx_pkg::VCX_DIR_WORK;
      end else if (filt[2]) begin
         dir = vcx_pkg::VCX_DIR_PROT;
      end else if (cmd_r == vcx_pkg::VCX_MANUAL_PROT) begin
         dir = vcx_pkg::VCX_DIR_PROT;
      end else if (cmd_r == vcx_pkg::VCX_MANUAL_WORK && !rev) begin
         dir = vcx_pkg::VCX_DIR_WORK;
      end
   end

   assign wtr_done = (wtr_cnt_r >= wtr_ms);
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         vcx_pkg::VCX_ST_WORK: begin
            if (dir == vcx_pkg::VCX_DIR_PROT) begin
               state_nxt = vcx_pkg::VCX_ST_PROT;
            end
         end
         vcx_pkg::VCX_ST_PROT: begin
            if (dir == vcx_pkg::VCX_DIR_WORK) begin
               state_nxt = vcx_pkg::VCX_ST_WORK;
            end else if (dir == vcx_pkg::VCX_DIR_NONE && rev) begin
               state_nxt = vcx_pkg::VCX_ST_WTR;
            end
         end
         vcx_pkg::VCX_ST_WTR: begin
            if (dir == vcx_pkg::VCX_DIR_PROT) begin
               state_nxt = vcx_pkg::VCX_ST_PROT;
            end else if (dir == vcx_pkg::VCX_DIR_WORK || wtr_done) begin
               state_nxt = vcx_pkg::VCX_ST_WORK;
            end else if (!rev) begin
               state_nxt = vcx_pkg::VCX_ST_PROT;
            end
         end
         default: state_nxt = vcx_pkg::VCX_ST_WORK;
      endcase
      if (!pg_r.en) begin
         state_nxt = vcx_pkg::VCX_ST_WORK;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r   <= vcx_pkg::VCX_ST_WORK;
         wtr_cnt_r <= 20'h0;
      end else begin
         state_r <= state_nxt;
         if (state_r != vcx_pkg::VCX_ST_WTR) begin
            wtr_cnt_r <= 20'h0;
         end else if (ms_tick && !wtr_done) begin
            wtr_cnt_r <= wtr_cnt_r + 20'h1;
         end
      end
   end

   // The restore period keeps traffic on protection until it ends.
   assign sel_prot = (state_r != vcx_pkg::VCX_ST_WORK);

   // Changing attributes of a route whose source stays the same alters
   // no mux select, so the passing stream is not disturbed.
   generate
      for (g = 0; g < NCP; g++) begin : g_out
         logic                 sink;
         logic                 bridge;
         logic                 used;
         logic [1:0]           src;
         vcx_pkg::vcx_cp_out_t out_r;
         assign sink   = pg_r.en & (pg_r.n_out == 2'(g));
         assign bridge = pg_r.en & pg_r.bidir &
                         (pg_r.w_out == 2'(g) | pg_r.p_out == 2'(g));
         assign src    = sink ? (sel_prot ? pg_r.p_in : pg_r.w_in)
                       : bridge ? pg_r.n_in : route_r[g].src;
         assign used   = sink | bridge | route_r[g].en;
         assign cp_o[g] = out_r;
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               out_r <= '0;
            end else if (used) begin
               out_r <= sy2_r[src][12:2];
            end else begin
               out_r <= uneq;
            end
         end
      end
   endgenerate

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_route;
      route_r[0].en && !pg_r.en |=> cp_o[0].data == $past(sy2_r[route_r[0].src].data);
   endproperty
   a_route: assert property (p_route) else $error("route data wrong");

   property p_uneq;
      !route_r[0].en && !pg_r.en |=>
         cp_o[0].data == 8'h00 && !cp_o[0].ssf && cp_o[0].fs == $past(ref2_r[1]);
   endproperty
   a_uneq: assert property (p_uneq) else $error("unequipped fill wrong");

   property p_teardown;
      wr_en && paddr_i == `VCX_OFS_ROUTE0 && !pwdata_i[0] && !pg_r.en
         ##1 !pg_r.en |=> cp_o[0].data == 8'h00 && !cp_o[0].ssf;
   endproperty
   a_teardown: assert property (p_teardown) else $error("teardown failed");

   property p_bridge;
      pg_r.en && pg_r.bidir && $stable(pg_r) |=>
         cp_o[pg_r.w_out] == cp_o[pg_r.p_out];
   endproperty
   a_bridge: assert property (p_bridge) else $error("bridge mismatch");

   property p_sink;
      pg_r.en && $stable(pg_r) |=> cp_o[pg_r.n_out].data ==
         $past(sy2_r[sel_prot ? pg_r.p_in : pg_r.w_in].data);
   endproperty
   a_sink: assert property (p_sink) else $error("selector output wrong");

   property p_lockout;
      pg_r.en && cmd_r == vcx_pkg::VCX_LOCKOUT_CMD |=> !sel_prot;
   endproperty
   a_lockout: assert property (p_lockout) else $error("lockout ignored");

   property p_force_work;
      pg_r.en && !rev && cmd_r == vcx_pkg::VCX_FORCE_WORK |=> !sel_prot;
   endproperty
   a_force_work: assert property (p_force_work) else $error("force ignored");

   property p_holdoff;
      $rose(filt[0]) |-> $past(raw[0]) && $past(ho_ms) <= $past(g_hold[0].cnt_r);
   endproperty
   a_holdoff: assert property (p_holdoff) else $error("hold-off skipped");

   property p_wtr;
      state_r == vcx_pkg::VCX_ST_WTR && !wtr_done && rev && pg_r.en &&
         dir == vcx_pkg::VCX_DIR_NONE |=> sel_prot;
   endproperty
   a_wtr: assert property (p_wtr) else $error("left restore early");

   property p_degrade;
      inh |-> raw[2] == 1'b0 && raw[3] == 1'b0;
   endproperty
   a_degrade: assert property (p_degrade) else $error("degrade used inherent");

   property p_sf_rank;
      pg_r.en && filt[0] && !filt[1] && cmd_r == vcx_pkg::VCX_MANUAL_WORK
         |=> sel_prot;
   endproperty
   a_sf_rank: assert property (p_sf_rank) else $error("fail outranked");

   c_switch: cover property (!sel_prot ##1 sel_prot);
   c_wtr:    cover property (state_r == vcx_pkg::VCX_ST_WTR ##1 !sel_prot);
   c_uneq:   cover property (!route_r[1].en && !pg_r.en ##1 cp_o[1].fs);
endmodule
`default_nettype wire

// ---- tb/vcx_trail_source_model.sv ----
// Far-side model: four trail sources and the timing reference.
`timescale 1ns/1ps
`default_nettype none
`include "vcx_consts.svh"
module vcx_trail_source_model (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   // Fault indications commanded by the bench
   input  wire logic [3:0]           ssf_i,
   input  wire logic [3:0]           tsf_i,
   input  wire logic [3:0]           tsd_i,
   // Streams and reference
   output var vcx_pkg::vcx_cp_in_t   stream_o [`VCX_NCP],
   output logic                      ref_clk_o,
   output logic                      ref_fs_o
);
   logic [2:0] ph_r;
   logic [5:0] byte_r;
   logic [2:0] ref_ph;
   // One byte per 800 ns link period, eight system clocks.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ph_r   <= 3'h0;
         byte_r <= 6'h00;
      end else begin
         ph_r <= ph_r + 3'h1;
         if (ph_r == 3'h7) begin
            byte_r <= byte_r + 6'h01;
         end
      end
   end
   // Each port gets its own tag, and odd ports an inverted clock phase, so a wrong route shows.
   always_comb begin
      for (int p = 0; p < `VCX_NCP; p++) begin
         stream_o[p].data = {2'(p), byte_r};
         stream_o[p].clk  = ph_r[2] ^ p[0];
         stream_o[p].fs   = (byte_r[3:0] == 4'h0);
         stream_o[p].ssf  = ssf_i[p];
         stream_o[p].tsf  = tsf_i[p];
         stream_o[p].tsd  = tsd_i[p];
      end
   end
   assign ref_ph    = ph_r + 3'h2;
   assign ref_clk_o = ref_ph[2];
   assign ref_fs_o  = (byte_r[3:0] == 4'h8);
endmodule
`default_nettype wire

// ---- tb/tb_vcx_cross_connect.sv ----
// Self-checking bench for the path cross-connect matrix.
`timescale 1ns/1ps
`default_nettype none
`include "vcx_consts.svh"
module tb_vcx_cross_connect;
   logic                clk_i = 1'b0;
   logic                rst_b_i = 1'b0;
   logic                psel_i = 1'b0;
   logic                penable_i = 1'b0;
   logic                pwrite_i = 1'b0;
   logic [7:0]          paddr_i = 8'h00;
   logic [31:0]         pwdata_i = 32'h0;
   logic [31:0]         prdata_o;
   logic                pready_o;
   logic                pslverr_o;
   logic                ref_clk;
   logic                ref_fs;
   logic [3:0]          ssf = 4'h0;
   logic [3:0]          tsf = 4'h0;
   logic [3:0]          tsd = 4'h0;
   logic [1:0]          r1, r2, r3;
   vcx_pkg::vcx_cp_in_t cp_i [`VCX_NCP];
   vcx_pkg::vcx_cp_in_t d1 [`VCX_NCP];
   vcx_pkg::vcx_cp_in_t d2 [`VCX_NCP];
   vcx_pkg::vcx_cp_in_t d3 [`VCX_NCP];
   vcx_pkg::vcx_cp_out_t cp_o [`VCX_NCP];
   int                  fail_count = 0;
   int                  n_checks = 0;
   int                  cyc = 0;
   localparam logic [31:0] CFG = 32'h00009C93;

   vcx_cross_connect #(.MS_CYCLES(4)) vcx_cross_connect_i (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .cp_i(cp_i), .timing_ref_clock_i(ref_clk),
      .timing_ref_fs_i(ref_fs), .cp_o(cp_o));
   vcx_trail_source_model vcx_trail_source_model_i (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .ssf_i(ssf), .tsf_i(tsf),
      .tsd_i(tsd), .stream_o(cp_i), .ref_clk_o(ref_clk),
      .ref_fs_o(ref_fs));

   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // Outputs lag inputs by three edges, so the expectation is delayed too.
   always_ff @(posedge clk_i) begin
      d1 <= cp_i;
      d2 <= d1;
      d3 <= d2;
      r1 <= {ref_clk, ref_fs};
      r2 <= r1;
      r3 <= r2;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // Only the bench timeout ends a wait for the slave's answer.
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
      chk({31'h0, err}, 32'h0);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic exp_err);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, exp_err});
   endtask
   // Source 4 stands for the generated unequipped signal.
   task automatic route_is(input int k, input int s, input int n);
      vcx_pkg::vcx_cp_out_t e;
      repeat (n) begin
         @(negedge clk_i);
         if (s == 4)
            e = {8'h00, r3[1], r3[0], 1'b0};
         else
            e = {d3[s].data, d3[s].clk, d3[s].fs, d3[s].ssf};
         chk(32'(cp_o[k]), 32'(e));
      end
      @(posedge clk_i);
   endtask
   task automatic sel_is(input logic exp);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, `VCX_OFS_STATUS, 32'h0, rd, err);
      chk({31'h0, rd[0]}, {31'h0, exp});
      route_is(2, exp ? 1 : 0, 8);
   endtask

   task automatic t_reset;
      rd_chk(`VCX_OFS_TIMES, 32'h00000500, 1'b0);
      rd_chk(`VCX_OFS_STATUS, 32'h0, 1'b0);
      for (int k = 0; k < `VCX_NCP; k++) begin
         route_is(k, 4, 20);
      end
   endtask
   task automatic t_route;
      wr(`VCX_OFS_ROUTE0 + 8'h04, 32'h0000000D);
      rd_chk(`VCX_OFS_ROUTE0 + 8'h04, 32'h0000000D, 1'b0);
      tick(6);
      fork
         route_is(1, 2, 40);
         wr(`VCX_OFS_ROUTE0 + 8'h0C, 32'h00000005);
      join
      route_is(3, 2, 20);
      route_is(0, 4, 10);
      ssf[2] <= 1'b1;
      tick(6);
      route_is(1, 2, 10);
      ssf[2] <= 1'b0;
      wr(`VCX_OFS_ROUTE0 + 8'h04, 32'h0);
      wr(`VCX_OFS_ROUTE0 + 8'h0C, 32'h0);
      tick(6);
      route_is(1, 4, 20);
      route_is(3, 4, 10);
      wr(`VCX_OFS_ROUTE0, 32'h00000003);
      tick(6);
      route_is(0, 1, 10);
      wr(`VCX_OFS_ROUTE0, 32'h0);
      tick(6);
      route_is(0, 4, 10);
   endtask
   task automatic t_refused;
      logic [31:0] rd;
      logic        err;
      apb(1'b1, 8'h20, 32'hFFFFFFFF, rd, err);
      chk({31'h0, err}, 32'h1);
      rd_chk(8'h02, 32'h0, 1'b1);
   endtask
   task automatic t_nonrevert;
      wr(`VCX_OFS_TIMES, 32'h0);
      wr(`VCX_OFS_PG_CFG, CFG);
      tick(6);
      route_is(2, 0, 20);
      route_is(0, 3, 10);
      route_is(1, 3, 10);
      tsf[0] <= 1'b1;
      tick(12);
      sel_is(1'b1);
      tsf[0] <= 1'b0;
      tick(12);
      sel_is(1'b1);
      for (int i = 1; i < 6; i++) begin
         wr(`VCX_OFS_CMD, 32'(i));
         tick(6);
         sel_is(i % 2 == 0);
      end
      wr(`VCX_OFS_CMD, 32'h0);
      tsd[0] <= 1'b1;
      tick(12);
      sel_is(1'b1);
      tsd[0] <= 1'b0;
      wr(`VCX_OFS_CMD, 32'h3);
      wr(`VCX_OFS_CMD, 32'h4);
      tick(6);
      sel_is(1'b1);
      tsf[1] <= 1'b1;
      tick(12);
      sel_is(1'b0);
      tsf[1] <= 1'b0;
      wr(`VCX_OFS_CMD, 32'h3);
      wr(`VCX_OFS_CMD, 32'h0);
      wr(`VCX_OFS_PG_CFG, CFG & 32'hFFFFFFF9);
      tsd[0] <= 1'b1;
      tsf[0] <= 1'b1;
      tick(12);
      sel_is(1'b0);
      ssf[0] <= 1'b1;
      tick(12);
      sel_is(1'b1);
      {ssf[0], tsf[0], tsd[0]} <= 3'h0;
      wr(`VCX_OFS_CMD, 32'h3);
      wr(`VCX_OFS_CMD, 32'h0);
   endtask
   task automatic t_revert;
      wr(`VCX_OFS_PG_CFG, CFG | 32'h8);
      wr(`VCX_OFS_TIMES, 32'h00000001);
      tsf[0] <= 1'b1;
      tick(300);
      sel_is(1'b0);
      tick(200);
      sel_is(1'b1);
      tsf[0] <= 1'b0;
      tick(20);
      sel_is(1'b0);
      wr(`VCX_OFS_CMD, 32'h1);
      tsf[0] <= 1'b1;
      tick(500);
      sel_is(1'b0);
      tsf[0] <= 1'b0;
      wr(`VCX_OFS_CMD, 32'h2);
      tick(6);
      sel_is(1'b1);
      wr(`VCX_OFS_CMD, 32'h0);
      tick(20);
      sel_is(1'b0);
   endtask

   initial begin
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_route();
      t_refused();
      t_nonrevert();
      t_revert();
      results();
   end
endmodule
`default_nettype wire
